// *** common/sso_pkg.sv ***
// package: widths, reset values and the pipeline operation carrier for the burst SRAM select/output block
package sso_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int ADDR_W     = 17;  // address bits
    localparam int DATA_W     = 36;  // 32 data bits plus 4 parity bits
    localparam int WORD_W     = 32;  // plain data bits
    localparam int LANES      = 4;   // byte lanes, each 8 data bits plus one parity bit
    localparam int LANE_W     = 8;   // data bits per lane
    localparam int PAR_POS    = 32;  // bus position of the first parity bit
    localparam int LOW_W      = 2;   // burst address bits
    localparam int BURST_LEN  = 4;   // words in one burst

    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [LOW_W-1:0]  RST_LOW     = 2'h0;
    localparam logic [LOW_W-1:0]  CNT_STEP    = 2'h1;
    localparam logic [DATA_W-1:0] RST_DATA    = 36'h0;
    localparam logic [ADDR_W-1:0] RST_ADDR    = 17'h0;
    localparam logic [LANES-1:0]  RST_BYTES_N = 4'hF;
    localparam int                DATA_LAT    = 2;   // command edge to data edge, in cycles

    // one operation travelling down the command pipeline
    typedef struct packed {
        logic                valid;    // a read or write is in flight
        logic                write;    // 1 write, 0 read
        logic [LANES-1:0]    byteWrN;  // byte write enables, active low
        logic [ADDR_W-1:0]   addr;     // word address used
    } sso_op_t;

    localparam sso_op_t RST_OP = '{valid: 1'b0, write: 1'b0, byteWrN: RST_BYTES_N, addr: RST_ADDR};

    // burst state
    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } sso_burst_t;

endpackage : sso_pkg

// *** hdl/sso_burst_counter.sv ***
// burst counter: produces the two low address bits in linear or interleaved order
`timescale 1ns/100ps
module sso_burst_counter (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      hold,
    input  wire logic                      load,
    input  wire logic                      advance,
    input  wire logic [sso_pkg::LOW_W-1:0] startLow,
    input  wire logic                      interleaved,
    output logic      [sso_pkg::LOW_W-1:0] nextLow
);
    import sso_pkg::*;

    logic [LOW_W-1:0] start_ff;
    logic [LOW_W-1:0] count_ff;
    logic [LOW_W-1:0] nxt_start;
    logic [LOW_W-1:0] nxt_count;
    logic [LOW_W-1:0] stepCount;
    logic [LOW_W-1:0] linLow;
    logic [LOW_W-1:0] intLow;

    // ************************************************************
    // address order
    // ************************************************************
    // count wraps modulo four by its own width
    assign stepCount = LOW_W'(count_ff + CNT_STEP);
    assign linLow    = LOW_W'(start_ff + stepCount);   // RULE12
    assign intLow    = start_ff ^ stepCount;           // RULE13
    // interleaved when the order select is high
    assign nextLow   = load ? startLow : (interleaved ? intLow : linLow); // RULE6

    // next state
    assign nxt_start = (!hold && load) ? startLow : start_ff;
    assign nxt_count = hold ? count_ff : (load ? RST_LOW : (advance ? stepCount : count_ff));

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_ff <= RST_LOW;
            count_ff <= RST_LOW;
        end else begin
            start_ff <= nxt_start;
            count_ff <= nxt_count;
        end
    end

endmodule : sso_burst_counter

// *** hdl/sso_select_output_ctrl.sv ***
// device-side select, deselect, output enable and burst order logic of a pipelined burst SRAM
//
// How it works
// RULE1: low load/advance with any chip enable false starts a deselect cycle.
// RULE2: bus goes high impedance two cycles after deselect; earlier transfers still finish.
// RULE3: the active-high chip enable behaves like the active-low ones, inverted.
// RULE4: all pins act on the rising clock; output enable acts without the clock.
// RULE5: write data captured and read data launched from registers on all 36 bits.
// RULE6: order select high gives interleaved bursts, low gives linear bursts.
// RULE7: the controller keeps the burst order select static.
// RULE8: output enable high forces every data pin to high impedance.
// RULE9: the controller holds output enable low to see read data; may tie it.
// RULE10: selected only when both low enables are low and the high one high.
// RULE11: load/advance low while selected loads address; high advances the burst counter.
// RULE12: linear order adds one modulo four to the low bits, then wraps.
// RULE13: interleaved order XORs the start with the count, wrapping after four.
// RULE14: deselect and no-op cycles never disturb a transfer issued two cycles before.
`timescale 1ns/100ps
module sso_select_output_ctrl (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // host-side control pins, same clock as the host
    input  wire logic                       clock_gate_n,
    input  wire logic                       select_low_a,
    input  wire logic                       select_low_b,
    input  wire logic                       select_high,
    input  wire logic                       advance_or_load,
    input  wire logic                       burst_order_sel,
    input  wire logic                       readNotWrite,
    input  wire logic [sso_pkg::LANES-1:0]  byteWrite_n,
    input  wire logic [sso_pkg::ADDR_W-1:0] address,
    input  wire logic                       outputEnable_n,
    // two-way data pins, split
    input  wire logic [sso_pkg::DATA_W-1:0] dataIn,
    output logic      [sso_pkg::DATA_W-1:0] dataOut,
    output logic                            dataOe_n,
    // memory array side
    output logic      [sso_pkg::ADDR_W-1:0] arrRdAddr,
    input  wire logic [sso_pkg::DATA_W-1:0] arrRdData,
    output logic                            arrWrEn,
    output logic      [sso_pkg::ADDR_W-1:0] arrWrAddr,
    output logic      [sso_pkg::DATA_W-1:0] arrWrData,
    output logic      [sso_pkg::LANES-1:0]  arrWrByteEn
);
    import sso_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    sso_burst_t        burst_ff;
    sso_burst_t        nxt_burst;
    sso_op_t           stage1_ff;
    sso_op_t           stage2_ff;
    sso_op_t           nxt_stage1;
    sso_op_t           nxt_stage2;
    logic [ADDR_W-1:0] base_ff;
    logic [ADDR_W-1:0] nxt_base;
    logic [DATA_W-1:0] rdPipe_ff;
    logic [DATA_W-1:0] nxt_rdPipe;
    logic [DATA_W-1:0] dataOut_ff;
    logic [DATA_W-1:0] nxt_dataOut;
    logic              drive_ff;
    logic              nxt_drive;
    logic [ADDR_W-1:0] rdAddr_ff;
    logic [ADDR_W-1:0] nxt_rdAddr;
    logic              wrEn_ff;
    logic              nxt_wrEn;
    logic [ADDR_W-1:0] wrAddr_ff;
    logic [ADDR_W-1:0] nxt_wrAddr;
    logic [DATA_W-1:0] wrData_ff;
    logic [DATA_W-1:0] nxt_wrData;
    logic [LANES-1:0]  wrBytes_ff;
    logic [LANES-1:0]  nxt_wrBytes;

    logic              hold;
    logic              selected;
    logic              loadCmd;
    logic              deselectCmd;
    logic              advanceCmd;
    logic              issue;
    logic [LOW_W-1:0]  burstLow;
    logic [ADDR_W-1:0] cmdAddr;
    logic              burstIsWrite;

    // ************************************************************
    // command decode
    // ************************************************************
    // high clock gate blocks the whole edge
    assign hold         = clock_gate_n;
    // the high enable counts the same as the low ones, inverted
    assign selected     = !select_low_a && !select_low_b && select_high; // RULE10 RULE3
    assign loadCmd      = !advance_or_load && selected;                  // RULE11
    assign deselectCmd  = !advance_or_load && !selected;                 // RULE1
    assign advanceCmd   = advance_or_load && (burst_ff != BURST_IDLE);   // RULE11
    assign issue        = loadCmd || advanceCmd;
    assign burstIsWrite = loadCmd ? !readNotWrite : (burst_ff == BURST_WRITE);
    // external address on load, counter bits on advance
    assign cmdAddr      = loadCmd ? address : {base_ff[ADDR_W-1:LOW_W], burstLow}; // RULE11

    sso_burst_counter u_burst (
        .clk         (clk),
        .rst_n       (rst_n),
        .hold        (hold),
        .load        (loadCmd),
        .advance     (advanceCmd),
        .startLow    (address[LOW_W-1:0]),
        .interleaved (burst_order_sel),
        .nextLow     (burstLow)
    );

    // ************************************************************
    // burst state
    // ************************************************************
    always_comb begin
        nxt_burst = burst_ff;
        if (!hold) begin
            case (burst_ff)
                BURST_IDLE,
                BURST_READ,
                BURST_WRITE: begin
                    if (loadCmd) begin
                        nxt_burst = readNotWrite ? BURST_READ : BURST_WRITE;
                    end else if (deselectCmd) begin
                        nxt_burst = BURST_IDLE;  // RULE1
                    end
                end
                default: nxt_burst = BURST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // two-stage operation pipeline
    // ************************************************************
    // deselect and no-op only insert an empty slot behind older work
    assign nxt_base   = (!hold && loadCmd) ? address : base_ff;
    assign nxt_stage1 = hold ? stage1_ff :
                        '{valid: issue, write: burstIsWrite, byteWrN: byteWrite_n, addr: cmdAddr};
    assign nxt_stage2 = hold ? stage2_ff : stage1_ff;  // RULE14
    assign nxt_rdAddr = hold ? rdAddr_ff : cmdAddr;

    // read word taken from the array one cycle after the address
    assign nxt_rdPipe = (!hold && stage1_ff.valid && !stage1_ff.write) ? arrRdData : rdPipe_ff;

    // ************************************************************
    // data launch and capture, two cycles after the command
    // ************************************************************
    assign nxt_drive   = hold ? drive_ff : (stage2_ff.valid && !stage2_ff.write);  // RULE2
    assign nxt_dataOut = (!hold && stage2_ff.valid && !stage2_ff.write) ? rdPipe_ff : dataOut_ff; // RULE5
    assign nxt_wrEn    = !hold && stage2_ff.valid && stage2_ff.write;
    assign nxt_wrAddr  = nxt_wrEn ? stage2_ff.addr : wrAddr_ff;
    assign nxt_wrData  = nxt_wrEn ? dataIn : wrData_ff;                            // RULE5
    assign nxt_wrBytes = nxt_wrEn ? ~stage2_ff.byteWrN : wrBytes_ff;

    // ************************************************************
    // registers, all on the rising edge
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin // RULE4
        if (!rst_n) begin
            burst_ff  <= BURST_IDLE;
            base_ff   <= RST_ADDR;
            stage1_ff <= RST_OP;
            stage2_ff <= RST_OP;
            rdAddr_ff <= RST_ADDR;
            rdPipe_ff <= RST_DATA;
        end else begin
            burst_ff  <= nxt_burst;
            base_ff   <= nxt_base;
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
            rdAddr_ff <= nxt_rdAddr;
            rdPipe_ff <= nxt_rdPipe;
        end
    end

    // output and input data registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_ff   <= 1'b0;
            dataOut_ff <= RST_DATA;
            wrEn_ff    <= 1'b0;
            wrAddr_ff  <= RST_ADDR;
            wrData_ff  <= RST_DATA;
            wrBytes_ff <= 4'h0;
        end else begin
            drive_ff   <= nxt_drive;
            dataOut_ff <= nxt_dataOut;
            wrEn_ff    <= nxt_wrEn;
            wrAddr_ff  <= nxt_wrAddr;
            wrData_ff  <= nxt_wrData;
            wrBytes_ff <= nxt_wrBytes;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign dataOut     = dataOut_ff;
    // output enable gates the pins without the clock
    assign dataOe_n    = !drive_ff || outputEnable_n;  // RULE8 RULE4
    assign arrRdAddr   = rdAddr_ff;
    assign arrWrEn     = wrEn_ff;
    assign arrWrAddr   = wrAddr_ff;
    assign arrWrData   = wrData_ff;
    assign arrWrByteEn = wrBytes_ff;

endmodule : sso_select_output_ctrl

// *** dv/sso_checker.sv ***
// checker: select, deselect, output enable and burst order timing at the block pins
`timescale 1ns/100ps
module sso_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        clock_gate_n,
    input wire logic        select_low_a,
    input wire logic        select_low_b,
    input wire logic        select_high,
    input wire logic        advance_or_load,
    input wire logic        burst_order_sel,
    input wire logic        readNotWrite,
    input wire logic        outputEnable_n,
    input wire logic        dataOe_n,
    input wire logic        arrWrEn,
    input wire logic [16:0] address,
    input wire logic [16:0] arrRdAddr,
    input wire logic [16:0] arrWrAddr,
    input wire logic [35:0] dataIn,
    input wire logic [35:0] arrWrData
);
    // decoded command at each rising edge
    wire sel = !select_low_a && !select_low_b && select_high;
    wire go  = !clock_gate_n;
    wire ld  = go && !advance_or_load;
    wire adv = go && advance_or_load;
    logic [16:0] ldAddr_ff;
    // address of the last load, kept for the burst step checks
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) ldAddr_ff <= 17'h0;
        else if (ld && sel) ldAddr_ff <= address;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd; ld && sel && readNotWrite; endsequence
    sequence s_wr; ld && sel && !readNotWrite; endsequence
    sequence s_desel; ld && !sel; endsequence
    a_oe_forces_hiz: assert property (outputEnable_n |-> dataOe_n)
        else $error("pins driven while output enable high");
    a_read_drives: assert property (s_rd ##1 go ##1 go ##1 !outputEnable_n |-> !dataOe_n)
        else $error("read word not driven two cycles later");
    a_desel_hiz: assert property (s_desel ##1 go ##1 go |=> dataOe_n)
        else $error("bus not released two cycles after deselect");
    a_desel_inflight: assert property (s_rd ##1 s_desel ##1 go ##1 !outputEnable_n |-> !dataOe_n)
        else $error("deselect cut an earlier read");
    a_write_lands: assert property (s_wr ##1 go ##1 go |=> arrWrEn && arrWrAddr == $past(address, 3)
        && arrWrData == $past(dataIn)) else $error("write word lost or misplaced");
    a_step_linear: assert property (s_rd ##1 (adv && !burst_order_sel)
        |=> arrRdAddr[1:0] == ldAddr_ff[1:0] + 2'h1) else $error("linear step wrong");
    a_step_inter: assert property (s_rd ##1 (adv && burst_order_sel)
        |=> arrRdAddr[1:0] == (ldAddr_ff[1:0] ^ 2'h1)) else $error("interleaved step wrong");
    a_burst_wrap: assert property (s_rd ##1 adv [*4] |=> arrRdAddr == ldAddr_ff)
        else $error("burst did not wrap to its start");
endmodule : sso_checker

bind sso_select_output_ctrl sso_checker chk_u (.clk, .rst_n, .clock_gate_n, .select_low_a, .select_low_b,
    .select_high, .advance_or_load, .burst_order_sel, .readNotWrite, .outputEnable_n, .dataOe_n, .arrWrEn,
    .address, .arrRdAddr, .arrWrAddr, .dataIn, .arrWrData);

// *** dv/sso_array_model.sv ***
// partner model: memory array behind the block, combinational read and byte-lane writes
`timescale 1ns/100ps
module sso_array_model (
    input  wire logic        clk,
    input  wire logic [16:0] rdAddr,
    output logic      [35:0] rdData,
    input  wire logic        wrEn,
    input  wire logic [16:0] wrAddr,
    input  wire logic [35:0] wrData,
    input  wire logic [3:0]  wrByteEn
);
    logic [35:0] mem [0:255];
    // preset contents so every read returns a known word
    initial for (int i = 0; i < 256; i++) mem[i] = {12'h9A5, 16'hC300, 8'(i)};
    assign rdData = mem[rdAddr[7:0]];
    // each enabled lane takes its data byte and its parity bit
    always @(posedge clk)
        if (wrEn) for (int l = 0; l < 4; l++) if (wrByteEn[l]) begin
            mem[wrAddr[7:0]][8*l +: 8] <= wrData[8*l +: 8];
            mem[wrAddr[7:0]][32+l] <= wrData[32+l];
        end
endmodule : sso_array_model

// *** dv/test_sync_sram_select_output_ctrl.sv ***
// testbench: burst reads, deselects and byte writes through the select/output block
`timescale 1ns/100ps
module test_sync_sram_select_output_ctrl;
    import sso_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, csA = 1'b0, csB = 1'b0, csH = 1'b1, aol = 1'b1, bos = 1'b0;
    logic        rnw = 1'b1, oeN = 1'b0, hostDrv = 1'b0, dOeN, wrEn;
    logic [3:0]  bwN = 4'h0, wrBe;
    logic [16:0] addr = 17'h0, rdA, wrA;
    logic [35:0] hostData = 36'h0, dIn, dOut, rdD, wrD;
    int          n_mismatch = 0, comparisons = 0;
    // pin level: device, host, or a changing float pattern
    assign dIn = !dOeN ? dOut : hostDrv ? hostData : ~dOut;
    initial forever #20 clk = ~clk;
    sso_select_output_ctrl dut_u (.clk(clk), .rst_n(rst_n), .clock_gate_n(1'b0), .select_low_a(csA),
        .select_low_b(csB), .select_high(csH), .advance_or_load(aol), .burst_order_sel(bos), .readNotWrite(rnw),
        .byteWrite_n(bwN), .address(addr), .outputEnable_n(oeN), .dataIn(dIn), .dataOut(dOut), .dataOe_n(dOeN),
        .arrRdAddr(rdA), .arrRdData(rdD), .arrWrEn(wrEn), .arrWrAddr(wrA), .arrWrData(wrD), .arrWrByteEn(wrBe));
    sso_array_model arr_u (.clk(clk), .rdAddr(rdA), .rdData(rdD), .wrEn(wrEn), .wrAddr(wrA), .wrData(wrD),
        .wrByteEn(wrBe));
    function automatic logic [35:0] word(input logic [16:0] a);
        return {12'h9A5, 16'hC300, a[7:0]};
    endfunction : word
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask : chk
    task automatic cmd(input logic ld, input logic r, input logic [16:0] a);
        @(negedge clk);
        aol = !ld;
        rnw = r;
        addr = a;
    endtask : cmd
    // five-word read burst, fifth wraps, then deselect through the high enable
    task automatic t_read(input logic inter, input logic [16:0] base);
        logic [1:0] lo;
        bos = inter;
        for (int j = 0; j < 9; j++) begin
            cmd(j == 0 || j == 5, 1'b1, j == 0 ? base : 17'h1FFFF);
            csH = (j != 5);
            // output enable held high across one edge, low again after it
            oeN = (j == 4);
            #1;
            if (j == 4) chk(36'(dOeN), 36'h1, "pins driven with oe high");
            // the deselect brings no word, so the last word stays on the register
            lo = inter ? base[1:0] ^ 2'(j == 8 ? 4 : j - 3) : base[1:0] + 2'(j == 8 ? 4 : j - 3);
            if (j >= 3) chk(dOut, word({base[16:2], lo}), "read word");
            if (j >= 3) chk(36'(dOeN), 36'(j == 4 || j == 8), "read drive state");
        end
        chk(36'(dOeN), 36'h1, "bus held after deselect");
        $display("t_read done, order %0d", inter);
    endtask : t_read
    // deselect by each chip enable right after a read load
    task automatic t_desel;
        for (int k = 0; k < 3; k++) begin
            cmd(1'b1, 1'b1, 17'h40);
            cmd(1'b1, 1'b1, 17'h44);
            {csA, csB, csH} = 3'h1 ^ (3'h4 >> k);
            cmd(1'b0, 1'b1, 17'h0);
            {csA, csB, csH} = 3'h1;
            cmd(1'b0, 1'b1, 17'h0);
            chk(dOut, word(17'h40), "read lost at deselect");
            cmd(1'b0, 1'b1, 17'h0);
            chk(36'(dOeN), 36'h1, "no release after deselect");
        end
        $display("t_desel done");
    endtask : t_desel
    // four-word linear write burst from offset 2, one word with two lanes
    task automatic t_write;
        logic [35:0] m;
        logic [7:0]  a;
        bos = 1'b0;
        for (int j = 0; j < 8; j++) begin
            cmd(j == 0 || j == 4, 1'b0, 17'h82);
            csH = (j != 4);
            bwN = (j == 1) ? 4'hA : 4'h0;
            hostDrv = (j >= 2 && j < 6);
            hostData = 36'hF12345600 + 36'(j - 2);
        end
        hostDrv = 1'b0;
        for (int i = 0; i < 4; i++) begin
            a = {6'h20, 2'(2 + i)};
            m = (i == 1) ? 36'h500FF00FF : 36'hFFFFFFFFF;
            chk(arr_u.mem[a], ((36'hF12345600 + 36'(i)) & m) | (word(17'(a)) & ~m), "written word");
        end
        $display("t_write done");
    endtask : t_write
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // watchdog at 1000 cycles, well beyond the 44 cycles the tests need
    initial begin
        #40000;
        n_mismatch++;
        stop_test();
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_read(1'b1, 17'h01);
        t_read(1'b0, 17'h13);
        t_desel();
        t_write();
        stop_test();
    end
endmodule : test_sync_sram_select_output_ctrl
